// ---- rtl/etwa_defines.svh ----
// Constants of the two-wire EEPROM slave front end.
// Assumes inclusion by bare name from package and design files.
`ifndef ETWA_DEFINES_SVH
`define ETWA_DEFINES_SVH

// Slave address byte layout
`define ETWA_SA_TYPE_MSB   3'h7
`define ETWA_SA_TYPE_LSB   3'h4
`define ETWA_SA_SEL_HI     3'h3
`define ETWA_SA_SEL_MID    3'h2
`define ETWA_SA_BLOCK      3'h1
`define ETWA_SA_RW         3'h0
`define ETWA_RW_READ       1'h1

// Bit counter: eight data clocks, the ninth is the acknowledge clock
`define ETWA_ACK_CNT       4'h8
`define ETWA_FIRST_CNT     4'h1

// Page rollover: sixteen bytes share the upper address bits
`define ETWA_PAGE_MSB      3'h3

// Write cycle time in milliseconds and the clock rate in kHz
`define ETWA_WR_TIME_HI_MS 10
`define ETWA_WR_TIME_LO_MS 15
`define ETWA_CLK_KHZ       50000

`endif

// ---- rtl/etwa_pkg.sv ----
// Types of the two-wire EEPROM slave front end.
// Assumes etwa_defines.svh is on the include path.
`include "etwa_defines.svh"

package etwa_pkg;

	typedef enum logic [2:0] {
		ETWA_IDLE,
		ETWA_ADDR,
		ETWA_WORD,
		ETWA_WDATA,
		ETWA_RDATA,
		ETWA_IGNORE
	} etwa_state_t;

	typedef struct packed {
		logic [3:0] dev_type;
		logic       sel_hi;
		logic       sel_mid;
		logic       block;
		logic       rw;
	} etwa_slave_addr_t;

	typedef struct packed {
		logic       block;
		logic [7:0] byte_addr;
	} etwa_array_addr_t;

endpackage : etwa_pkg

// ---- rtl/etwa_slave.sv ----
// Two-wire serial EEPROM slave: address decode, acknowledge, memory
// array and the self-timed write cycle.
// Assumes scl_i/sda_i come from a pulled-up open-drain bus; the bench
// resolves the line from sda_oe. scl_i is the link clock.
`timescale 1ns/1ps
`include "etwa_defines.svh"

module etwa_slave
	import etwa_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE   = 4'h5, // Arbitrary value
	parameter int         WR_CYC_HI  = `ETWA_WR_TIME_HI_MS * `ETWA_CLK_KHZ,
	parameter int         WR_CYC_LO  = `ETWA_WR_TIME_LO_MS * `ETWA_CLK_KHZ,
	parameter int         MEM_BYTES  = 512
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	input  wire logic device_select_pin_high,
	input  wire logic device_select_pin_mid,
	input  wire logic write_protect,
	input  wire logic low_supply,
	output logic      write_busy
);

	localparam int TMR_W = 24;

	// Refused at elaboration: the timer cannot count these lengths
	if (WR_CYC_HI < 1 || WR_CYC_LO < 1 ||
	    WR_CYC_HI >= (1 << TMR_W) ||
	    WR_CYC_LO >= (1 << TMR_W)) begin : g_bad_cyc
		$error("etwa_slave: write cycle count out of range");
	end
	if (MEM_BYTES != 512) begin : g_bad_mem
		$error("etwa_slave: array must hold two 256-byte blocks");
	end

	// ---------------------------------------------------------------
	// Start and stop detectors, clocked by the data line itself.
	// Each flips a toggle; the clock pin is read directly because the
	// bus holds it high well before and after either condition.
	// ---------------------------------------------------------------
	logic start_tgl_q;
	logic stop_tgl_q;

	always_ff @(negedge sda_i or posedge rst) begin
		if (rst)
			start_tgl_q <= 1'h0;
		else if (scl_i)
			start_tgl_q <= ~start_tgl_q;
	end

	always_ff @(posedge sda_i or posedge rst) begin
		if (rst)
			stop_tgl_q <= 1'h0;
		else if (scl_i)
			stop_tgl_q <= ~stop_tgl_q;
	end

	// ---------------------------------------------------------------
	// Link domain (scl rising edge samples, falling edge drives)
	// ---------------------------------------------------------------
	etwa_state_t      state_q;
	etwa_state_t      state_d;
	logic [3:0]       cnt_q;
	logic [7:0]       shr_q;
	logic [7:0]       tx_q;
	etwa_array_addr_t addr_q;
	logic             st_seen_q;
	logic             sp_seen_q;
	logic             wrote_q;
	logic             wr_tgl_q;
	logic             busy_s1_q;
	logic             busy_s2_q;
	logic             wp_s1_q;
	logic             wp_s2_q;
	logic             selh_s1_q;
	logic             selh_s2_q;
	logic             selm_s1_q;
	logic             selm_s2_q;
	logic [7:0]       mem [MEM_BYTES];

	function automatic logic [7:0] etwa_page_inc(input logic [7:0] a);
		// Page write rolls over inside its sixteen-byte page
		etwa_page_inc = {a[7:4], a[`ETWA_PAGE_MSB:0] + 4'h1};
	endfunction : etwa_page_inc

	wire              new_start = start_tgl_q != st_seen_q;
	wire              new_stop  = stop_tgl_q != sp_seen_q;
	wire              ack_clk   = cnt_q == `ETWA_ACK_CNT;
	etwa_slave_addr_t sa;
	assign sa = etwa_slave_addr_t'(shr_q);
	wire type_ok  = sa.dev_type == DEV_TYPE;
	wire sel_ok   = sa.sel_hi == selh_s2_q &&
	                sa.sel_mid == selm_s2_q;
	wire addr_hit = type_ok && sel_ok && !busy_s2_q;
	wire is_read  = sa.rw == `ETWA_RW_READ;
	wire prot     = wp_s2_q && addr_q.block;
	wire [8:0] mem_idx = addr_q;
	wire [8:0] rd_next = {addr_q.block, addr_q.byte_addr + 8'h01};

	// Whether this device pulls the line low on the coming ninth clock
	wire ack_ok = (state_q == ETWA_ADDR  && addr_hit) ||
	              (state_q == ETWA_WORD) ||
	              (state_q == ETWA_WDATA && !prot);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ETWA_ADDR: begin
				if (!addr_hit)
					state_d = ETWA_IGNORE;
				else if (is_read)
					state_d = ETWA_RDATA;
				else
					state_d = ETWA_WORD;
			end
			ETWA_WDATA: begin
				if (prot)
					state_d = ETWA_IGNORE;
			end
			ETWA_WORD: state_d = ETWA_WDATA;
			ETWA_RDATA: begin
				if (sda_i)
					state_d = ETWA_IGNORE;
			end
			default: state_d = state_q;
		endcase
	end

	always_ff @(posedge scl_i or posedge rst) begin
		if (rst) begin
			busy_s1_q <= 1'h0;
			busy_s2_q <= 1'h0;
			wp_s1_q   <= 1'h0;
			wp_s2_q   <= 1'h0;
			selh_s1_q <= 1'h0;
			selh_s2_q <= 1'h0;
			selm_s1_q <= 1'h0;
			selm_s2_q <= 1'h0;
		end else begin
			busy_s1_q <= write_busy;
			busy_s2_q <= busy_s1_q;
			wp_s1_q   <= write_protect;
			wp_s2_q   <= wp_s1_q;
			selh_s1_q <= device_select_pin_high;
			selh_s2_q <= selh_s1_q;
			selm_s1_q <= device_select_pin_mid;
			selm_s2_q <= selm_s1_q;
		end
	end

	always_ff @(posedge scl_i or posedge rst) begin
		if (rst) begin
			st_seen_q <= 1'h0;
			sp_seen_q <= 1'h0;
		end else begin
			st_seen_q <= start_tgl_q;
			sp_seen_q <= stop_tgl_q;
		end
	end

	// Frame sequencer: the edge after a start carries the first bit
	always_ff @(posedge scl_i or posedge rst) begin
		if (rst) begin
			state_q <= ETWA_IDLE;
			cnt_q   <= 4'h0;
			shr_q   <= 8'h00;
		end else if (new_start) begin
			state_q <= ETWA_ADDR;
			cnt_q   <= `ETWA_FIRST_CNT;
			shr_q   <= {7'h00, sda_i};
		end else if (new_stop) begin
			state_q <= ETWA_IDLE;
			cnt_q   <= 4'h0;
		end else if (state_q != ETWA_IDLE && state_q != ETWA_IGNORE) begin
			if (ack_clk) begin
				state_q <= state_d;
				cnt_q   <= 4'h0;
			end else begin
				shr_q <= {shr_q[6:0], sda_i};
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	// Address pointer, array and the write-pending toggle
	always_ff @(posedge scl_i or posedge rst) begin
		if (rst) begin
			addr_q   <= '0;
			tx_q     <= 8'h00;
			wrote_q  <= 1'h0;
			wr_tgl_q <= 1'h0;
		end else if (new_start) begin
			wrote_q <= 1'h0;
		end else if (!new_stop && ack_clk) begin
			case (state_q)
				ETWA_ADDR: begin
					if (addr_hit) begin
						// Read uses the block just addressed, not the old one
						addr_q.block <= sa.block;
						tx_q         <= mem[{sa.block, addr_q.byte_addr}];
					end
				end
				ETWA_WORD: addr_q.byte_addr <= shr_q;
				ETWA_WDATA: begin
					if (!prot) begin
						addr_q.byte_addr <= etwa_page_inc(addr_q.byte_addr);
						wrote_q          <= 1'h1;
						if (!wrote_q)
							wr_tgl_q <= ~wr_tgl_q;
					end
				end
				ETWA_RDATA: begin
					addr_q.byte_addr <= rd_next[7:0];
					tx_q             <= mem[rd_next];
				end
				default: addr_q <= addr_q;
			endcase
		end
	end

	// Storage has no reset; contents are what was last programmed
	always_ff @(posedge scl_i) begin
		if (!new_start && !new_stop && ack_clk &&
		    state_q == ETWA_WDATA && !prot)
			mem[mem_idx] <= shr_q;
	end

	// Line driver on the falling edge, so data only moves while low
	wire [2:0] tx_sel  = 3'h7 - cnt_q[2:0];
	wire       drv_ack = ack_clk && ack_ok;
	wire       drv_bit = state_q == ETWA_RDATA && !ack_clk &&
	                     !tx_q[tx_sel];
	always_ff @(negedge scl_i or posedge rst) begin
		if (rst) begin
			sda_oe <= 1'h0;
			sda_o  <= 1'h0;
		end else begin
			sda_o <= 1'h0;
			// Release wins: pending start, stop or write cycle
			if (new_start || new_stop || busy_s2_q)
				sda_oe <= 1'h0;
			else
				sda_oe <= drv_ack || drv_bit;
		end
	end

	// ---------------------------------------------------------------
	// System clock domain: stop detection and write cycle timer
	// ---------------------------------------------------------------
	logic             sp_s1_q;
	logic             sp_s2_q;
	logic             sp_s3_q;
	logic             wt_s1_q;
	logic             wt_s2_q;
	logic             wr_done_q;
	logic             lo_s1_q;
	logic             lo_s2_q;
	logic [TMR_W-1:0] tmr_q;

	wire stop_evt  = sp_s2_q ^ sp_s3_q;
	wire wr_start  = stop_evt && (wt_s2_q != wr_done_q) && !write_busy;
	wire [TMR_W-1:0] tmr_load = lo_s2_q ? TMR_W'(WR_CYC_LO)
	                                    : TMR_W'(WR_CYC_HI);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sp_s1_q <= 1'h0;
			sp_s2_q <= 1'h0;
			sp_s3_q <= 1'h0;
			wt_s1_q <= 1'h0;
			wt_s2_q <= 1'h0;
			lo_s1_q <= 1'h0;
			lo_s2_q <= 1'h0;
		end else begin
			sp_s1_q <= stop_tgl_q;
			sp_s2_q <= sp_s1_q;
			sp_s3_q <= sp_s2_q;
			wt_s1_q <= wr_tgl_q;
			wt_s2_q <= wt_s1_q;
			lo_s1_q <= low_supply;
			lo_s2_q <= lo_s1_q;
		end
	end

	// A stop after accepted data starts the self-timed write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_done_q  <= 1'h0;
			tmr_q      <= '0;
			write_busy <= 1'h0;
		end else if (wr_start) begin
			wr_done_q  <= wt_s2_q;
			tmr_q      <= tmr_load - TMR_W'(1);
			write_busy <= 1'h1;
		end else if (write_busy) begin
			tmr_q <= tmr_q - TMR_W'(1);
			if (tmr_q == '0)
				write_busy <= 1'h0;
		end
	end

endmodule : etwa_slave

// ---- tb/etwa_slave_asserts.sv ----
// Port checker for the two-wire EEPROM slave.
// Assumes bind onto etwa_slave with its write cycle lengths.
`timescale 1ns/1ps

module etwa_slave_asserts #(
	parameter int WR_CYC_HI = 20,
	parameter int WR_CYC_LO = 30
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic low_supply,
	input wire logic write_busy
);
	logic [31:0] cnt_q;
	int          lim;

	assign lim = low_supply ? WR_CYC_LO : WR_CYC_HI;

	// Counts clk edges with the write cycle seen high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt_q <= 32'h0;
		else cnt_q <= write_busy ? cnt_q + 32'h1 : 32'h0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_open_drain: assert property (sda_o == 1'b0)
		else $error("sda_o driven high");
	chk_busy_quiet: assert property (write_busy |-> !sda_oe)
		else $error("line pulled during write cycle");
	chk_busy_start: assert property ($rose(write_busy) |-> scl_i && sda_i)
		else $error("write cycle began inside a frame");
	chk_busy_length: assert property ($fell(write_busy) |->
		cnt_q >= lim && cnt_q <= lim + 1)
		else $error("write cycle length wrong");
	chk_busy_once: assert property ($fell(write_busy) |=>
		!write_busy [*3])
		else $error("write cycle restarted");
	chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data changed while clock high");
	chk_ack_wire: assert property (sda_oe |-> !sda_i)
		else $error("pulled line reads high");
	chk_reset_quiet: assert property (disable iff (1'b0)
		rst |-> !sda_oe && !write_busy)
		else $error("outputs active in reset");

	cov_write: cover property ($rose(write_busy));
	cov_ack: cover property (sda_oe && scl_i);
	cov_slow: cover property ($fell(write_busy) && low_supply);
endmodule : etwa_slave_asserts

bind etwa_slave etwa_slave_asserts #(
	.WR_CYC_HI(WR_CYC_HI),
	.WR_CYC_LO(WR_CYC_LO)
) i_chk (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .low_supply(low_supply),
	.write_busy(write_busy));

// ---- tb/etwa_master.sv ----
// Two-wire bus master model: makes the serial clock, pulls data low.
// Assumes the bench resolves the pulled-up line from all enables.
`timescale 1ns/1ps

module etwa_master (
	output logic      scl,
	output logic      m_oe,
	input  wire logic sda
);
	localparam realtime Q = 31.25;

	initial begin
		scl  = 1'b1;
		m_oe = 1'b0;
	end

	// Offset keeps serial edges off the system clock grid
	task automatic idle2;
		#7.3;
		repeat (2) begin
			#62.5 scl = 1'b0;
			#62.5 scl = 1'b1;
		end
	endtask : idle2

	task automatic start;
		#7.3;
		if (!scl) begin
			m_oe = 1'b0;
			#Q scl = 1'b1;
		end
		#Q m_oe = 1'b1;
		#Q scl = 1'b0;
	endtask : start

	task automatic sbit(input logic b, output logic r);
		#Q m_oe = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask : sbit

	// Ack slot with a high releases the line for the receiver
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
		sbit(a, k);
	endtask : xfer

	// Clock then stands high until the next frame
	task automatic stop;
		#Q m_oe = 1'b1;
		#Q scl = 1'b1;
		#Q m_oe = 1'b0;
		#Q;
	endtask : stop
endmodule : etwa_master

// ---- tb/etwa_slave_tb_top.sv ----
// Testbench: master model, pulled-up data line and the slave.
// Assumes straps start high and mid low, short write cycles.
`timescale 1ns/1ps

module etwa_slave_tb_top;
	import etwa_pkg::*;
	localparam logic [3:0] TYPE = 4'h5; // Arbitrary value
	logic clk, rst, scl, m_oe, wp, slow, sda_o, sda_oe, busy;
	logic pin_hi, pin_mid;
	wire  sda;
	int   errors, num_checks;

	assign sda = !(sda_oe || m_oe);

	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end

	etwa_master i_master (.scl(scl), .m_oe(m_oe), .sda(sda));

	etwa_slave #(.DEV_TYPE(TYPE), .WR_CYC_HI(200), .WR_CYC_LO(300)) i_dut (
		.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .device_select_pin_high(pin_hi),
		.device_select_pin_mid(pin_mid), .write_protect(wp),
		.low_supply(slow), .write_busy(busy));

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	function automatic logic [7:0] sa(logic hi, md, bk, rw);
		return {TYPE, hi, md, bk, rw};
	endfunction : sa

	task automatic bwait(input logic v);
		for (int i = 0; i < 400 && busy !== v; i++) @(negedge clk);
	endtask : bwait

	task automatic wr(input logic bk, input logic [7:0] a, d,
		input logic da);
		logic [7:0] q;
		logic       k;
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, bk, 1'b0), 1'b1, q, k);
		chk("slave ack", 8'h0, 8'(k));
		i_master.xfer(a, 1'b1, q, k);
		chk("word ack", 8'h0, 8'(k));
		i_master.xfer(d, 1'b1, q, k);
		chk("data ack", 8'(da), 8'(k));
		i_master.stop();
	endtask : wr

	task automatic rd(input logic bk, input logic [7:0] a, e);
		logic [7:0] q;
		logic       k;
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, bk, 1'b0), 1'b1, q, k);
		i_master.xfer(a, 1'b1, q, k);
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, bk, 1'b1), 1'b1, q, k);
		chk("read ack", 8'h0, 8'(k));
		i_master.xfer(8'hFF, 1'b1, q, k);
		chk("read data", e, q);
		i_master.stop();
	endtask : rd

	task automatic t_write_cycle;
		logic [7:0] q;
		logic       k;
		wr(1'b0, 8'h10, 8'hA5, 1'b0);
		bwait(1'b1);
		chk("busy after stop", 8'h1, 8'(busy));
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, 1'b0, 1'b0), 1'b1, q, k);
		chk("ack while busy", 8'h1, 8'(k));
		i_master.stop();
		bwait(1'b0);
		chk("busy end", 8'h0, 8'(busy));
		rd(1'b0, 8'h10, 8'hA5);
	endtask : t_write_cycle

	task automatic t_mismatch;
		logic [7:0] q, m [3];
		logic       k;
		m = '{{TYPE ^ 4'h1, 4'h8}, sa(1'b0, 1'b0, 1'b0, 1'b0),
			sa(1'b1, 1'b1, 1'b0, 1'b0)};
		foreach (m[i]) begin
			i_master.start();
			i_master.xfer(m[i], 1'b1, q, k);
			chk("foreign ack", 8'h1, 8'(k));
			i_master.xfer(8'h00, 1'b1, q, k);
			chk("ignored byte", 8'h1, 8'(k));
			i_master.stop();
		end
		// Swapped straps: only the matching select bits get an answer
		@(posedge clk) {pin_hi, pin_mid} <= 2'h1;
		for (int i = 0; i < 2; i++) begin
			i_master.start();
			i_master.xfer(sa(i[0], !i[0], 1'b0, 1'b0), 1'b1, q, k);
			chk("strap ack", 8'(i), 8'(k));
			i_master.stop();
		end
		@(posedge clk) {pin_hi, pin_mid} <= 2'h2;
	endtask : t_mismatch

	task automatic t_blocks;
		@(posedge clk) slow <= 1'b1;
		wr(1'b1, 8'h10, 8'h3C, 1'b0);
		bwait(1'b1);
		bwait(1'b0);
		rd(1'b0, 8'h10, 8'hA5);
		rd(1'b1, 8'h10, 8'h3C);
		@(posedge clk) wp <= 1'b1;
		wr(1'b1, 8'h10, 8'h77, 1'b1);
		bwait(1'b1);
		chk("protected cycle", 8'h0, 8'(busy));
		rd(1'b1, 8'h10, 8'h3C);
		wr(1'b0, 8'h20, 8'h5A, 1'b0);
		bwait(1'b1);
		bwait(1'b0);
		rd(1'b0, 8'h20, 8'h5A);
	endtask : t_blocks

	// Two-byte page write that wraps at the page end, then a two-byte read
	task automatic t_page_seq;
		logic [7:0] q;
		logic       k;
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, 1'b0, 1'b0), 1'b1, q, k);
		i_master.xfer(8'h1F, 1'b1, q, k);
		i_master.xfer(8'hC3, 1'b1, q, k);
		chk("page ack 1", 8'h0, 8'(k));
		i_master.xfer(8'h96, 1'b1, q, k);
		chk("page ack 2", 8'h0, 8'(k));
		i_master.stop();
		bwait(1'b1);
		bwait(1'b0);
		chk("page busy end", 8'h0, 8'(busy));
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, 1'b0, 1'b0), 1'b1, q, k);
		i_master.xfer(8'h1F, 1'b1, q, k);
		i_master.start();
		i_master.xfer(sa(1'b1, 1'b0, 1'b0, 1'b1), 1'b1, q, k);
		i_master.xfer(8'hFF, 1'b0, q, k);
		chk("seq byte 1", 8'hC3, q);
		i_master.xfer(8'hFF, 1'b1, q, k);
		chk("seq byte 2", 8'h5A, q);
		i_master.stop();
		rd(1'b0, 8'h10, 8'h96);
	endtask : t_page_seq

	initial begin
		errors     = 0;
		num_checks = 0;
		rst        = 1'b1;
		wp         = 1'b0;
		slow       = 1'b0;
		pin_hi     = 1'b1;
		pin_mid    = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		i_master.idle2();
		t_write_cycle();
		t_mismatch();
		t_blocks();
		t_page_seq();
		finish_test();
	end

	initial begin
		#400000;
		errors++;
		finish_test();
	end
endmodule : etwa_slave_tb_top
